// *** src/drdac_host.sv ***
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module drdac_host (
  input  wire logic                              clk_in,
  input  wire logic                              arst_n_in,
  input  wire drdac_pkg::drdac_bus_s             bus_in,
  output logic        [drdac_pkg::DATA_W-1:0]    rd_data_out,
  output logic                                   busy_out,
  output drdac_pkg::drdac_pins_s                 dac_pins_out
);

  drdac_pkg::drdac_state_s q;
  drdac_pkg::drdac_state_s n;
  drdac_pkg::drdac_phase_s ph_q;
  drdac_pkg::drdac_phase_s ph_n;
  logic                    act;
  logic                    pulse;
  logic                    cmd_wr;

  // Cycle counts, loaded as count minus one
  localparam logic [drdac_pkg::CNT_W-1:0] CNT_SETUP =
    drdac_pkg::CNT_W'(drdac_pkg::SETUP_CYC - 1);
  localparam logic [drdac_pkg::CNT_W-1:0] CNT_PULSE =
    drdac_pkg::CNT_W'(drdac_pkg::PULSE_CYC - 1);
  localparam logic [drdac_pkg::CNT_W-1:0] CNT_HOLD =
    drdac_pkg::CNT_W'(drdac_pkg::HOLD_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe plan for one write cycle of the transfer
  function automatic drdac_pkg::drdac_phase_s plan(
    input drdac_pkg::drdac_mode_e mode,
    input logic                   low_first,
    input logic                   defer,
    input logic                   upd,
    input logic [1:0]             phase
  );
    drdac_pkg::drdac_phase_s p;
    logic                    first_hi;
    p        = '0;
    first_hi = !low_first;
    if (upd)
    begin
      // Load alone, also the shared update of several converters
      p.ld   = 1'b1;
      p.last = 1'b1;
    end
    else
    begin
      unique case (mode)
        drdac_pkg::MODE_WIDE:
        begin
          p.hi   = 1'b1;
          p.lo   = 1'b1;
          p.last = 1'b1;
        end
        drdac_pkg::MODE_BYTE_SYNC:
        begin
          if (phase == 2'h0)
          begin
            p.hi = first_hi;
            p.lo = !first_hi;
          end
          else
          begin
            p.hi   = !first_hi;
            p.lo   = first_hi;
            p.ld   = !defer;
            p.last = 1'b1;
          end
        end
        default:
        begin
          // Separate load cycle after both bytes, left out when defer is set
          if (phase == 2'h0)
          begin
            p.hi = first_hi;
            p.lo = !first_hi;
          end
          else if (phase == 2'h1)
          begin
            p.hi   = !first_hi;
            p.lo   = first_hi;
            p.last = defer;
          end
          else
          begin
            p.ld   = 1'b1;
            p.last = 1'b1;
          end
        end
      endcase
    end
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    n      = q;
    ph_q   = plan(q.mode, q.low_first, q.defer, q.upd, q.phase);
    cmd_wr = bus_in.wr && (bus_in.addr == drdac_pkg::REG_CMD);

    // Read data stand for exactly the cycle after the strobe
    n.rdata = '0;
    if (bus_in.rd)
    begin
      unique case (bus_in.addr)
        drdac_pkg::REG_CTRL:
        begin
          n.rdata[drdac_pkg::CTRL_MODE_LSB +: drdac_pkg::CTRL_MODE_W] = q.mode;
          n.rdata[drdac_pkg::CTRL_LOW_FIRST_BIT] = q.low_first;
          n.rdata[drdac_pkg::CTRL_CS_STROBE_BIT] = q.cs_strobe;
          n.rdata[drdac_pkg::CTRL_DEFER_BIT]     = q.defer;
        end
        drdac_pkg::REG_CODE:
        begin
          n.rdata[drdac_pkg::CODE_W-1:0] = q.code;
        end
        drdac_pkg::REG_STATUS:
        begin
          n.rdata[drdac_pkg::STATUS_BUSY_BIT] = q.busy;
          n.rdata[drdac_pkg::STATUS_PEND_BIT] = q.pend;
          n.rdata[drdac_pkg::STATUS_CODE_LSB +: drdac_pkg::CODE_W] = q.shadow;
        end
        default:
        begin
          n.rdata = '0;
        end
      endcase
    end

    // Config is frozen while a transfer runs, so the plan cannot shift under it
    if (bus_in.wr && !q.busy && (bus_in.addr == drdac_pkg::REG_CTRL))
    begin
      n.mode = drdac_pkg::drdac_mode_e'(
        bus_in.wdata[drdac_pkg::CTRL_MODE_LSB +: drdac_pkg::CTRL_MODE_W]);
      n.low_first = bus_in.wdata[drdac_pkg::CTRL_LOW_FIRST_BIT];
      n.cs_strobe = bus_in.wdata[drdac_pkg::CTRL_CS_STROBE_BIT];
      n.defer     = bus_in.wdata[drdac_pkg::CTRL_DEFER_BIT];
    end
    if (bus_in.wr && (bus_in.addr == drdac_pkg::REG_CODE))
    begin
      n.code = bus_in.wdata[drdac_pkg::CODE_W-1:0];
    end

    unique case (q.st)
      drdac_pkg::ST_IDLE:
      begin
        if (cmd_wr && bus_in.wdata[drdac_pkg::CMD_START_BIT])
        begin
          n.shadow = q.code;
          n.upd    = 1'b0;
          n.phase  = 2'h0;
          n.busy   = 1'b1;
          n.st     = drdac_pkg::ST_SETUP;
          n.cnt    = CNT_SETUP;
        end
        else if (cmd_wr && bus_in.wdata[drdac_pkg::CMD_UPDATE_BIT] &&
                 (q.mode != drdac_pkg::MODE_WIDE))
        begin
          n.upd   = 1'b1;
          n.phase = 2'h0;
          n.busy  = 1'b1;
          n.st    = drdac_pkg::ST_SETUP;
          n.cnt   = CNT_SETUP;
        end
      end
      drdac_pkg::ST_SETUP:
      begin
        if (q.cnt == '0)
        begin
          n.st  = drdac_pkg::ST_STROBE;
          n.cnt = CNT_PULSE;
        end
        else
        begin
          n.cnt = q.cnt - 1'b1;
        end
      end
      drdac_pkg::ST_STROBE:
      begin
        if (q.cnt == '0)
        begin
          n.st  = drdac_pkg::ST_HOLD;
          n.cnt = CNT_HOLD;
        end
        else
        begin
          n.cnt = q.cnt - 1'b1;
        end
      end
      drdac_pkg::ST_HOLD:
      begin
        if (q.cnt != '0)
        begin
          n.cnt = q.cnt - 1'b1;
        end
        else if (ph_q.last)
        begin
          n.st   = drdac_pkg::ST_IDLE;
          n.busy = 1'b0;
          n.upd  = 1'b0;
          // First rank loaded, DAC register still waiting for the update
          n.pend = !q.upd && q.defer && (q.mode != drdac_pkg::MODE_WIDE);
        end
        else
        begin
          n.phase = q.phase + 2'h1;
          n.st    = drdac_pkg::ST_SETUP;
          n.cnt   = CNT_SETUP;
        end
      end
    endcase

    // Pins follow the next state so they leave straight from flip-flops
    ph_n  = plan(n.mode, n.low_first, n.defer, n.upd, n.phase);
    act   = (n.st != drdac_pkg::ST_IDLE);
    pulse = (n.st == drdac_pkg::ST_STROBE);
    if (n.cs_strobe)
    begin
      // Byte strobes stand as addresses, the select is the strobe
      n.pins.cs_n   = !pulse;
      n.pins.hbe_n  = !(act && ph_n.hi);
      n.pins.lbe_n  = !(act && ph_n.lo);
      n.pins.output_register_load_n_n = !(act && ph_n.ld);
    end
    else
    begin
      // Select is the decoded address, strobes carry the write pulse
      n.pins.cs_n   = !act;
      n.pins.hbe_n  = !(pulse && ph_n.hi);
      n.pins.lbe_n  = !(pulse && ph_n.lo);
      n.pins.output_register_load_n_n = !(pulse && ph_n.ld);
    end
    // Wide mode keeps the second rank transparent
    if (n.mode == drdac_pkg::MODE_WIDE)
    begin
      n.pins.output_register_load_n_n = 1'b0;
    end

    // Data change only in setup, after every strobe has risen
    if (n.st == drdac_pkg::ST_SETUP)
    begin
      if (ph_n.hi && !ph_n.lo)
      begin
        n.pins.data = {n.shadow[drdac_pkg::CODE_W-1 -: drdac_pkg::BYTE_W],
                       n.shadow[drdac_pkg::CODE_W-1 -: drdac_pkg::BYTE_W]};
      end
      else if (ph_n.lo && !ph_n.hi)
      begin
        n.pins.data = {n.shadow[0 +: drdac_pkg::BYTE_W],
                       n.shadow[0 +: drdac_pkg::BYTE_W]};
      end
      else if (!ph_n.ld)
      begin
        n.pins.data = n.shadow;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      q <= drdac_pkg::STATE_RST;
    end
    else
    begin
      q <= n;
    end
  end

  assign rd_data_out  = q.rdata;
  assign busy_out     = q.busy;
  assign dac_pins_out = q.pins;

endmodule

// *** src/drdac_pkg.sv ***
package drdac_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_SETUP_NS    = 60;
  localparam int unsigned T_PULSE_NS    = 70;
  localparam int unsigned T_HOLD_NS     = 20;

  // Least times round up, never below one cycle
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned CNT_W     = 8;
  localparam int unsigned SETUP_CYC = ns_to_cyc(T_SETUP_NS);
  localparam int unsigned PULSE_CYC = ns_to_cyc(T_PULSE_NS);
  localparam int unsigned HOLD_CYC  = ns_to_cyc(T_HOLD_NS);

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CODE_W = 16;
  localparam int unsigned BYTE_W = 8;

  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CODE   = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CMD    = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h3;

  localparam int unsigned CTRL_MODE_LSB      = 0;
  localparam int unsigned CTRL_MODE_W        = 2;
  localparam int unsigned CTRL_LOW_FIRST_BIT = 2;
  localparam int unsigned CTRL_CS_STROBE_BIT = 3;
  localparam int unsigned CTRL_DEFER_BIT     = 4;
  localparam int unsigned CMD_START_BIT      = 0;
  localparam int unsigned CMD_UPDATE_BIT     = 1;
  localparam int unsigned STATUS_BUSY_BIT    = 0;
  localparam int unsigned STATUS_PEND_BIT    = 1;
  localparam int unsigned STATUS_CODE_LSB    = 16;

  typedef enum logic [1:0] {
    MODE_WIDE      = 2'h0,
    MODE_BYTE_SYNC = 2'h1,
    MODE_BYTE_SEP  = 2'h2
  } drdac_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SETUP  = 4'h2,
    ST_STROBE = 4'h4,
    ST_HOLD   = 4'h8
  } drdac_state_e;

  typedef struct packed {
    logic [CODE_W-1:0] data;
    logic              cs_n;
    logic              hbe_n;
    logic              lbe_n;
    logic              output_register_load_n_n;
  } drdac_pins_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } drdac_bus_s;

  typedef struct packed {
    logic hi;
    logic lo;
    logic ld;
    logic last;
  } drdac_phase_s;

  typedef struct packed {
    drdac_state_e      st;
    logic [CNT_W-1:0]  cnt;
    logic [1:0]        phase;
    logic              upd;
    logic              busy;
    logic              pend;
    drdac_mode_e       mode;
    logic              low_first;
    logic              cs_strobe;
    logic              defer;
    logic [CODE_W-1:0] code;
    logic [CODE_W-1:0] shadow;
    logic [DATA_W-1:0] rdata;
    drdac_pins_s       pins;
  } drdac_state_s;

  localparam drdac_pins_s PINS_RST = '{data: 16'h0000, cs_n: 1'b1, hbe_n: 1'b1,
                                       lbe_n: 1'b1, output_register_load_n_n: 1'b1};

  localparam drdac_state_s STATE_RST = '{
    st: ST_IDLE, cnt: 8'h00, phase: 2'h0, upd: 1'b0, busy: 1'b0, pend: 1'b0,
    mode: MODE_BYTE_SEP, low_first: 1'b0, cs_strobe: 1'b0, defer: 1'b0,
    code: 16'h0000, shadow: 16'h0000, rdata: 32'h0000_0000, pins: PINS_RST};

endpackage

// *** tb/drdac_dev.sv ***
`timescale 1ns/1ps
// Behavioural converter input latches; both ranks are transparent latches
module drdac_dev (
  input  wire drdac_pkg::drdac_pins_s pins_in,
  output logic [15:0]                 code_out
);
  logic [7:0] hi_q;
  logic [7:0] lo_q;

  // No reset on purpose: the real part powers up unknown
  always_latch
    if (!pins_in.cs_n && !pins_in.hbe_n)
      hi_q <= pins_in.data[15:8];

  always_latch
    if (!pins_in.cs_n && !pins_in.lbe_n)
      lo_q <= pins_in.data[7:0];

  // Offset binary: 0000 is minus reference, ffff plus reference
  always_latch
    if (!pins_in.cs_n && !pins_in.output_register_load_n_n)
      code_out <= {hi_q, lo_q};
endmodule

// *** tb/drdac_host_assertions.sv ***
`timescale 1ns/1ps
module drdac_host_chk (
  input wire logic                         clk_in,
  input wire logic                         arst_n_in,
  input wire drdac_pkg::drdac_bus_s        bus_in,
  input wire logic [drdac_pkg::DATA_W-1:0] rd_data_out,
  input wire logic                         busy_out,
  input wire drdac_pkg::drdac_pins_s       dac_pins_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  wire        cs_n = dac_pins_out.cs_n;
  wire        hb   = dac_pins_out.hbe_n;
  wire        lb   = dac_pins_out.lbe_n;
  wire        ld   = dac_pins_out.output_register_load_n_n;
  wire [15:0] dat  = dac_pins_out.data;

  a_data_quiet: assert property ($changed(dat) |-> cs_n || (hb && lb))
    else $error("data bus moved while a latch was open");
  a_hold_after: assert property (!cs_n && !(hb && lb) |=> $stable(dat))
    else $error("data bus not held after strobe");
  a_idle_quiet: assert property (!busy_out |-> cs_n && hb && lb)
    else $error("strobe active while idle");
  a_one_overlap: assert property (!cs_n && !(hb && lb) |=> cs_n || (hb && lb))
    else $error("write pulse longer than one cycle");
  a_byte_mirror: assert property (hb != lb |-> dat[15:8] == dat[7:0])
    else $error("byte not on both halves");
  a_busy_span: assert property ($rose(busy_out) |-> busy_out[*3] ##[1:7] !busy_out)
    else $error("transfer length out of range");
  a_start_takes: assert property (bus_in.wr && bus_in.addr == drdac_pkg::REG_CMD
    && bus_in.wdata[1:0] == 2'h1 && !busy_out |=> busy_out)
    else $error("start not taken");
  a_sel_in_xfer: assert property ($fell(cs_n) |-> busy_out)
    else $error("select outside a transfer");

  c_xfer: cover property ($rose(busy_out));
  c_all_low: cover property (!cs_n && !hb && !lb && !ld);
  c_load_only: cover property (!cs_n && hb && lb && !ld);
  c_sync_load: cover property (!cs_n && hb && !lb && !ld);
endmodule

bind drdac_host drdac_host_chk chk_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus_in),
  .rd_data_out(rd_data_out), .busy_out(busy_out), .dac_pins_out(dac_pins_out));

// *** tb/tb_dual_rank_dac_input_latches.sv ***
`timescale 1ns/1ps
module tb_dual_rank_dac_input_latches;
  logic                         clk_in    = 1'b0;
  logic                         arst_n_in = 1'b0;
  drdac_pkg::drdac_bus_s        bus_in    = '0;
  logic [drdac_pkg::DATA_W-1:0] rd_data_out;
  logic                         busy_out;
  drdac_pkg::drdac_pins_s       dac_pins_out;
  logic [15:0]                  dac_code;
  int                           err_total   = 0;
  int                           check_count = 0;

  always #50 clk_in = ~clk_in;

  drdac_host dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus_in),
    .rd_data_out(rd_data_out), .busy_out(busy_out), .dac_pins_out(dac_pins_out));
  drdac_dev dev_u (.pins_in(dac_pins_out), .code_out(dac_code));

  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // One-cycle strobes; the gap edge keeps drivers from clashing
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_in.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_in.rd <= 1'b0;
    #1 d = rd_data_out;
  endtask

  task automatic wait_idle();
    int i;
    i = 0;
    do
    begin
      @(posedge clk_in);
      #1 i++;
    end
    while (busy_out !== 1'b0 && i < 40);
    if (i >= 40)
    begin
      err_total++;
      summarize();
    end
  endtask

  task automatic xfer(input logic [31:0] ctrl, input logic [15:0] code);
    wr(drdac_pkg::REG_CTRL, ctrl);
    wr(drdac_pkg::REG_CODE, {16'h0, code});
    wr(drdac_pkg::REG_CMD, 32'h1);
    wait_idle();
  endtask

  ////////////////////////////////////////////////////////////
  task automatic sc_wide();
    xfer(32'h0, 16'h1234);
    chk({16'h0, dac_code}, 32'h1234);
  endtask

  task automatic sc_sync();
    xfer(32'h1, 16'ha55a);
    chk({16'h0, dac_code}, 32'ha55a);
    xfer(32'h5, 16'h5aa5);
    chk({16'h0, dac_code}, 32'h5aa5);
  endtask

  task automatic sc_sep();
    xfer(32'h2, 16'hc3e1);
    chk({16'h0, dac_code}, 32'hc3e1);
    xfer(32'h3, 16'h00ff);
    chk({16'h0, dac_code}, 32'h00ff);
  endtask

  // Deferred load must leave the output alone until the update command
  task automatic sc_defer();
    logic [31:0] s;
    xfer(32'h12, 16'h0ff0);
    chk({16'h0, dac_code}, 32'h00ff);
    rd(drdac_pkg::REG_STATUS, s);
    chk(s, 32'h0ff0_0002);
    wr(drdac_pkg::REG_CMD, 32'h2);
    wait_idle();
    chk({16'h0, dac_code}, 32'h0ff0);
    rd(drdac_pkg::REG_STATUS, s);
    chk(s, 32'h0ff0_0000);
  endtask

  task automatic sc_cs();
    xfer(32'h9, 16'h8001);
    chk({16'h0, dac_code}, 32'h8001);
  endtask

  task automatic sc_regs();
    logic [31:0] s;
    rd(4'hf, s);
    chk(s, 32'h0);
    wr(drdac_pkg::REG_CODE, 32'h7ffe);
    wr(drdac_pkg::REG_CMD, 32'h1);
    rd(drdac_pkg::REG_STATUS, s);
    chk({31'h0, s[0]}, 32'h1);
    wait_idle();
    chk({16'h0, dac_code}, 32'h7ffe);
  endtask

  initial
  begin
    repeat (16) @(posedge clk_in);
    chk({12'h0, dac_pins_out}, 32'h0000f);
    arst_n_in <= 1'b1;
    sc_wide();
    sc_sync();
    sc_sep();
    sc_defer();
    sc_cs();
    sc_regs();
    summarize();
  end
endmodule
